// ### pkg/seb_pkg.sv
// Shared constants and types for the two-wire serial memory bus ends.
package seb_pkg;

    localparam int CLK_PERIOD_NS = 40;

    // Internal write cycle, a longest time: rounds down to whole cycles.
    localparam int INTERNAL_WRITE_CYCLE_TIME_MS = 5;
    localparam int WRITE_CYCLE_CYC = (INTERNAL_WRITE_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // Power-on to first command, a least time: rounds up to whole cycles.
    localparam int POWER_ON_TO_COMMAND_DELAY_US = 100;
    localparam int POWER_ON_CYC =
        (POWER_ON_TO_COMMAND_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Serial clock period made by the controller, split into four phases.
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QUARTER_CYC =
        (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    localparam int WORD_BITS = 8;
    localparam logic [3:0] BIT_CNT_WORD = 4'h8;
    localparam logic [3:0] RECOVER_CLOCKS_LAST = 4'h8;
    localparam logic [3:0] DEV_ADDR_PREFIX = 4'ha;

    typedef enum logic [2:0] {
        SEB_D_IDLE  = 3'b000,
        SEB_D_ADDR  = 3'b001,
        SEB_D_ACK   = 3'b010,
        SEB_D_RX    = 3'b011,
        SEB_D_TX    = 3'b100,
        SEB_D_TXACK = 3'b101
    } seb_dev_state_t;

    typedef enum logic [2:0] {
        SEB_H_INIT    = 3'b000,
        SEB_H_IDLE    = 3'b001,
        SEB_H_START   = 3'b010,
        SEB_H_STOP    = 3'b011,
        SEB_H_BYTE    = 3'b100,
        SEB_H_RECOVER = 3'b101
    } seb_host_state_t;

    typedef enum logic [2:0] {
        SEB_CMD_START   = 3'b000,
        SEB_CMD_STOP    = 3'b001,
        SEB_CMD_WRITE   = 3'b010,
        SEB_CMD_READ    = 3'b011,
        SEB_CMD_RECOVER = 3'b100
    } seb_cmd_t;

endpackage

// ### pkg/seb_if.sv
// Two-wire bus carrier: serial clock and the wired-AND open-drain data line.
`timescale 1ns/1ps
interface seb_if;
    logic scl;
    logic host_sda_oe;
    logic dev_sda_oe;
    logic sda;

    // Pull-up returns the line high unless some party pulls it low.
    assign sda = !(host_sda_oe | dev_sda_oe);

    modport host (
        output scl,
        output host_sda_oe,
        input sda
    );

    modport dev (
        input scl,
        input sda,
        output dev_sda_oe
    );
endinterface

// ### hdl/seb_device.sv
// Memory-side end of the two-wire bus: conditions, words, acknowledge, write cycle.
`timescale 1ns/1ps
module seb_device #(
    parameter int WRITE_CYC = seb_pkg::WRITE_CYCLE_CYC
) (
    seb_if.dev bus,
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic bus_clk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic tx_load,
    input wire logic [7:0] tx_data,
    output logic standby,
    output logic write_busy
);

    localparam int WCNT_W = $clog2(WRITE_CYC + 1);

    // Bus-side domain: oversamples the pins on bus_clk.
    logic [1:0] rst_sync, busy_l;
    logic [2:0] scl_p, sda_p, tx_tgl_l;
    logic lrst_n, scl_now, scl_old, sda_now, sda_old;
    logic start_det, stop_det, scl_rise, scl_fall;

    seb_pkg::seb_dev_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg;
    logic oe, next_oe;
    logic rw, next_rw;
    logic wrote, next_wrote;
    logic mack, next_mack;
    logic [7:0] rx_hold, next_rx_hold;
    logic rx_tgl, next_rx_tgl;
    logic wr_tgl, next_wr_tgl;
    logic [7:0] tx_word, next_tx_word;

    // System-side domain.
    logic [2:0] rx_s, wr_s;
    logic [1:0] act_s;
    logic [7:0] tx_word_sys, next_tx_word_sys, next_rx_data;
    logic tx_tgl_sys, next_tx_tgl_sys, next_write_busy, next_rx_valid, next_standby;
    logic [WCNT_W-1:0] wcnt, next_wcnt;

    // Reset reaches the bus domain through two flops and is then used synchronously.
    always_ff @(posedge bus_clk) begin
        rst_sync <= {rst_sync[0], rstn};
        scl_p <= {scl_p[1:0], bus.scl};
        sda_p <= {sda_p[1:0], bus.sda};
        busy_l <= {busy_l[0], write_busy};
        tx_tgl_l <= {tx_tgl_l[1:0], tx_tgl_sys};
    end
    assign lrst_n = rst_sync[1];

    assign scl_now = scl_p[1];
    assign scl_old = scl_p[2];
    assign sda_now = sda_p[1];
    assign sda_old = sda_p[2];
    // A data edge seen with the clock high on both samples is a condition, never a bit.
    assign start_det = scl_now & scl_old & sda_old & !sda_now;
    assign stop_det = scl_now & scl_old & !sda_old & sda_now;
    assign scl_rise = scl_now & !scl_old;
    assign scl_fall = !scl_now & scl_old;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_oe = oe;
        next_rw = rw;
        next_wrote = wrote;
        next_mack = mack;
        next_rx_hold = rx_hold;
        next_rx_tgl = rx_tgl;
        next_wr_tgl = wr_tgl;
        next_tx_word = tx_word;
        // The word is stable before its toggle arrives, so it is safe to copy here.
        if (tx_tgl_l[2] != tx_tgl_l[1]) begin
            next_tx_word = tx_word_sys;
        end
        if (stop_det) begin
            next_state = seb_pkg::SEB_D_IDLE;
            next_oe = 1'b0;
            next_wrote = 1'b0;
            if (wrote) begin
                next_wr_tgl = !wr_tgl;
            end
        end else if (start_det) begin
            next_oe = 1'b0;
            next_wrote = 1'b0;
            next_cnt = 4'h0;
            if (busy_l[1]) begin
                next_state = seb_pkg::SEB_D_IDLE;
            end else begin
                next_state = seb_pkg::SEB_D_ADDR;
            end
        end else if (scl_rise) begin
            unique case (state)
                seb_pkg::SEB_D_ADDR, seb_pkg::SEB_D_RX: begin
                    next_shreg = {shreg[6:0], sda_now};
                    next_cnt = 4'(cnt + 4'h1);
                end
                seb_pkg::SEB_D_TX: begin
                    next_shreg = {shreg[6:0], 1'b0};
                    next_cnt = 4'(cnt + 4'h1);
                end
                seb_pkg::SEB_D_TXACK: begin
                    next_mack = !sda_now;
                end
                seb_pkg::SEB_D_IDLE, seb_pkg::SEB_D_ACK: begin
                end
            endcase
        end else if (scl_fall) begin
            // Every drive change happens just after a falling clock edge.
            unique case (state)
                seb_pkg::SEB_D_ADDR: begin
                    if (cnt == seb_pkg::BIT_CNT_WORD) begin
                        if (shreg[7:4] == seb_pkg::DEV_ADDR_PREFIX) begin
                            next_oe = 1'b1;
                            next_rw = shreg[0];
                            next_state = seb_pkg::SEB_D_ACK;
                        end else begin
                            next_state = seb_pkg::SEB_D_IDLE;
                        end
                    end
                end
                seb_pkg::SEB_D_RX: begin
                    if (cnt == seb_pkg::BIT_CNT_WORD) begin
                        next_oe = 1'b1;
                        next_wrote = 1'b1;
                        next_rx_hold = shreg;
                        next_rx_tgl = !rx_tgl;
                        next_state = seb_pkg::SEB_D_ACK;
                    end
                end
                seb_pkg::SEB_D_ACK: begin
                    next_cnt = 4'h0;
                    if (rw) begin
                        next_state = seb_pkg::SEB_D_TX;
                        next_shreg = tx_word;
                        next_oe = !tx_word[7];
                    end else begin
                        next_state = seb_pkg::SEB_D_RX;
                        next_oe = 1'b0;
                    end
                end
                seb_pkg::SEB_D_TX: begin
                    if (cnt == seb_pkg::BIT_CNT_WORD) begin
                        next_oe = 1'b0;
                        next_state = seb_pkg::SEB_D_TXACK;
                    end else begin
                        next_oe = !shreg[7];
                    end
                end
                seb_pkg::SEB_D_TXACK: begin
                    if (mack) begin
                        next_state = seb_pkg::SEB_D_TX;
                        next_cnt = 4'h0;
                        next_shreg = tx_word;
                        next_oe = !tx_word[7];
                    end else begin
                        next_state = seb_pkg::SEB_D_IDLE;
                    end
                end
                seb_pkg::SEB_D_IDLE: begin
                end
            endcase
        end
    end

    always_ff @(posedge bus_clk) begin
        if (!lrst_n) begin
            state <= seb_pkg::SEB_D_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            oe <= 1'b0;
            rw <= 1'b0;
            wrote <= 1'b0;
            mack <= 1'b0;
            rx_hold <= 8'h00;
            rx_tgl <= 1'b0;
            wr_tgl <= 1'b0;
            tx_word <= 8'hff;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            oe <= next_oe;
            rw <= next_rw;
            wrote <= next_wrote;
            mack <= next_mack;
            rx_hold <= next_rx_hold;
            rx_tgl <= next_rx_tgl;
            wr_tgl <= next_wr_tgl;
            tx_word <= next_tx_word;
        end
    end

    assign bus.dev_sda_oe = oe;

    // System side: event toggles and the bus-activity level cross through flop chains.
    always_ff @(posedge sys_clk) begin
        rx_s <= {rx_s[1:0], rx_tgl};
        wr_s <= {wr_s[1:0], wr_tgl};
        act_s <= {act_s[0], (state != seb_pkg::SEB_D_IDLE)};
    end

    always_comb begin
        next_rx_valid = rx_s[2] ^ rx_s[1];
        next_rx_data = rx_data;
        if (rx_s[2] ^ rx_s[1]) begin
            next_rx_data = rx_hold;
        end
        next_tx_word_sys = tx_word_sys;
        next_tx_tgl_sys = tx_tgl_sys;
        if (tx_load) begin
            next_tx_word_sys = tx_data;
            next_tx_tgl_sys = !tx_tgl_sys;
        end
        next_write_busy = write_busy;
        next_wcnt = wcnt;
        if (wr_s[2] ^ wr_s[1]) begin
            next_write_busy = 1'b1;
            next_wcnt = WCNT_W'(WRITE_CYC - 1);
        end else if (write_busy) begin
            if (wcnt == '0) begin
                next_write_busy = 1'b0;
            end else begin
                next_wcnt = WCNT_W'(wcnt - 1'b1);
            end
        end
        next_standby = !act_s[1] & !next_write_busy;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            tx_word_sys <= 8'hff;
            tx_tgl_sys <= 1'b0;
            write_busy <= 1'b0;
            wcnt <= '0;
            standby <= 1'b1;
        end else begin
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            tx_word_sys <= next_tx_word_sys;
            tx_tgl_sys <= next_tx_tgl_sys;
            write_busy <= next_write_busy;
            wcnt <= next_wcnt;
            standby <= next_standby;
        end
    end

endmodule

// ### hdl/seb_host.sv
// Controller end of the two-wire bus: makes the clock and runs bus commands.
`timescale 1ns/1ps
module seb_host #(
    parameter int QUARTER_CYC = seb_pkg::SCL_QUARTER_CYC
) (
    seb_if.host bus,
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire seb_pkg::seb_cmd_t cmd,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_rd_ack,
    output logic done,
    output logic [7:0] rdata,
    output logic ack_seen,
    output logic recovered
);

    localparam int TICK_W = $clog2(QUARTER_CYC + 1);
    localparam int INIT_W = $clog2(seb_pkg::POWER_ON_CYC + 1);

    logic [1:0] sda_s;
    logic sda_in;
    seb_pkg::seb_host_state_t state;
    seb_pkg::seb_host_state_t next_state;
    logic [TICK_W-1:0] tick;
    logic [TICK_W-1:0] next_tick;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic scl;
    logic next_scl;
    logic oe;
    logic next_oe;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic op_rd;
    logic next_op_rd;
    logic mack;
    logic next_mack;
    logic [INIT_W-1:0] init_cnt;
    logic [INIT_W-1:0] next_init_cnt;
    logic next_done;
    logic [7:0] next_rdata;
    logic next_ack_seen;
    logic next_recovered;
    logic qend;

    always_ff @(posedge sys_clk) begin
        sda_s <= {sda_s[0], bus.sda};
    end
    assign sda_in = sda_s[1];
    assign qend = (tick == TICK_W'(QUARTER_CYC - 1));
    assign cmd_ready = (state == seb_pkg::SEB_H_IDLE);

    always_comb begin
        next_state = state;
        next_tick = tick;
        next_phase = phase;
        next_bitn = bitn;
        next_scl = scl;
        next_oe = oe;
        next_shreg = shreg;
        next_op_rd = op_rd;
        next_mack = mack;
        next_init_cnt = init_cnt;
        next_done = 1'b0;
        next_rdata = rdata;
        next_ack_seen = ack_seen;
        next_recovered = recovered;
        if (state != seb_pkg::SEB_H_INIT && state != seb_pkg::SEB_H_IDLE) begin
            next_tick = qend ? '0 : TICK_W'(tick + 1'b1);
            if (qend) begin
                next_phase = 2'(phase + 2'h1);
            end
        end
        // Each phase lasts one quarter clock; sda moves only while scl is low, except for the start and stop conditions.
        unique case (state)
            seb_pkg::SEB_H_INIT: begin
                if (init_cnt == INIT_W'(seb_pkg::POWER_ON_CYC - 1)) begin
                    next_state = seb_pkg::SEB_H_IDLE;
                end else begin
                    next_init_cnt = INIT_W'(init_cnt + 1'b1);
                end
            end
            seb_pkg::SEB_H_IDLE: begin
                next_tick = '0;
                next_phase = 2'h0;
                next_bitn = 4'h0;
                if (cmd_valid) begin
                    unique case (cmd)
                        seb_pkg::SEB_CMD_START: begin
                            next_state = seb_pkg::SEB_H_START;
                            next_oe = 1'b0;
                        end
                        seb_pkg::SEB_CMD_STOP: begin
                            next_state = seb_pkg::SEB_H_STOP;
                            next_scl = 1'b0;
                        end
                        seb_pkg::SEB_CMD_WRITE: begin
                            next_state = seb_pkg::SEB_H_BYTE;
                            next_op_rd = 1'b0;
                            next_shreg = cmd_wdata;
                            next_oe = !cmd_wdata[7];
                        end
                        seb_pkg::SEB_CMD_READ: begin
                            next_state = seb_pkg::SEB_H_BYTE;
                            next_op_rd = 1'b1;
                            next_mack = cmd_rd_ack;
                            next_oe = 1'b0;
                        end
                        seb_pkg::SEB_CMD_RECOVER: begin
                            next_state = seb_pkg::SEB_H_RECOVER;
                            next_scl = 1'b0;
                            next_oe = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            seb_pkg::SEB_H_START: begin
                if (qend) begin
                    unique case (phase)
                        2'h0: next_scl = 1'b1;
                        2'h1: next_oe = 1'b1;
                        2'h2: next_scl = 1'b0;
                        2'h3: begin
                            next_state = seb_pkg::SEB_H_IDLE;
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            seb_pkg::SEB_H_STOP: begin
                if (qend) begin
                    unique case (phase)
                        2'h0: next_oe = 1'b1;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_oe = 1'b0;
                        2'h3: begin
                            next_state = seb_pkg::SEB_H_IDLE;
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            seb_pkg::SEB_H_BYTE: begin
                if (qend) begin
                    unique case (phase)
                        2'h0: next_scl = 1'b1;
                        2'h1: begin
                            if (bitn == seb_pkg::BIT_CNT_WORD) begin
                                next_ack_seen = op_rd ? mack : !sda_in;
                            end else if (op_rd) begin
                                next_shreg = {shreg[6:0], sda_in};
                            end
                        end
                        2'h2: next_scl = 1'b0;
                        2'h3: begin
                            next_bitn = 4'(bitn + 4'h1);
                            if (!op_rd) begin
                                next_shreg = {shreg[6:0], 1'b0};
                            end
                            if (bitn == seb_pkg::BIT_CNT_WORD) begin
                                next_state = seb_pkg::SEB_H_IDLE;
                                next_done = 1'b1;
                                next_oe = 1'b0;
                                if (op_rd) begin
                                    next_rdata = shreg;
                                end
                            end else if (bitn == 4'(seb_pkg::WORD_BITS - 1)) begin
                                next_oe = op_rd & mack;
                            end else begin
                                next_oe = !op_rd & !shreg[6];
                            end
                        end
                    endcase
                end
            end
            seb_pkg::SEB_H_RECOVER: begin
                if (qend) begin
                    unique case (phase)
                        2'h0: next_scl = 1'b1;
                        2'h1: begin
                            if (sda_in) begin
                                next_state = seb_pkg::SEB_H_START;
                                next_phase = 2'h0;
                                next_recovered = 1'b1;
                            end
                        end
                        2'h2: next_scl = 1'b0;
                        2'h3: begin
                            next_bitn = 4'(bitn + 4'h1);
                            if (bitn == seb_pkg::RECOVER_CLOCKS_LAST) begin
                                next_state = seb_pkg::SEB_H_START;
                                next_recovered = 1'b0;
                            end
                        end
                    endcase
                end
            end
            default: begin
                next_state = seb_pkg::SEB_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= seb_pkg::SEB_H_INIT;
            tick <= '0;
            phase <= 2'h0;
            bitn <= 4'h0;
            scl <= 1'b1;
            oe <= 1'b0;
            shreg <= 8'h00;
            op_rd <= 1'b0;
            mack <= 1'b0;
            init_cnt <= '0;
            done <= 1'b0;
            rdata <= 8'h00;
            ack_seen <= 1'b0;
            recovered <= 1'b0;
        end else begin
            state <= next_state;
            tick <= next_tick;
            phase <= next_phase;
            bitn <= next_bitn;
            scl <= next_scl;
            oe <= next_oe;
            shreg <= next_shreg;
            op_rd <= next_op_rd;
            mack <= next_mack;
            init_cnt <= next_init_cnt;
            done <= next_done;
            rdata <= next_rdata;
            ack_seen <= next_ack_seen;
            recovered <= next_recovered;
        end
    end

    assign bus.scl = scl;
    assign bus.host_sda_oe = oe;

endmodule

// ### testbench/seb_bus_properties.sv
// Concurrent checks on the two-wire bus between the controller and the memory end.
`timescale 1ns/1ps
module seb_bus_properties #(
    parameter int WRITE_CYC = seb_pkg::WRITE_CYCLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe,
    input wire logic write_busy,
    input wire logic standby
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic scl_d;
    logic sda_d;
    logic [3:0] rises;
    logic [7:0] addr;
    logic busy_seen;
    int busy_cnt;
    logic start_seen;
    logic stop_seen;
    logic ninth;
    assign start_seen = scl && scl_d && !sda && sda_d;
    assign stop_seen = scl && scl_d && sda && !sda_d;
    assign ninth = scl && !scl_d && rises == 4'h8;
    // Rises are counted from each start, so only the address word is judged.
    always_ff @(posedge sys_clk) begin
        scl_d <= scl;
        sda_d <= sda;
        busy_cnt <= write_busy ? busy_cnt + 1 : 0;
        if (!rstn || start_seen) begin
            rises <= 4'h0;
            busy_seen <= write_busy;
        end else if (scl && !scl_d && rises != 4'hf) begin
            rises <= rises + 4'h1;
            addr <= {addr[6:0], sda};
        end else if (write_busy) begin
            busy_seen <= 1'b1;
        end
    end
    AST_DEV_DATA_STEADY: assert property (scl && scl_d |-> $stable(dev_sda_oe))
        else $error("device data moved while clock high");
    AST_ADDR_PHASE_QUIET: assert property (scl && scl_d && rises inside {[1:8]} |-> !dev_sda_oe)
        else $error("device drove during address word");
    AST_ACK_MATCH: assert property (ninth && !busy_seen &&
        addr[7:4] == seb_pkg::DEV_ADDR_PREFIX |-> dev_sda_oe)
        else $error("matching address not acknowledged");
    AST_ADDR_MISMATCH_NACK: assert property (ninth &&
        addr[7:4] != seb_pkg::DEV_ADDR_PREFIX |-> !dev_sda_oe)
        else $error("foreign address acknowledged");
    AST_BUSY_NO_ACK: assert property (ninth && busy_seen |-> !dev_sda_oe)
        else $error("acknowledge during write cycle");
    AST_BUSY_QUIET: assert property (write_busy |-> !dev_sda_oe)
        else $error("data line driven during write cycle");
    AST_BUSY_BOUND: assert property (write_busy |-> busy_cnt <= WRITE_CYC)
        else $error("write cycle too long");
    AST_STOP_TO_REST: assert property (stop_seen |-> ##[1:12] (standby || write_busy))
        else $error("no standby or write cycle after stop");
    AST_STANDBY_ACTIVE: assert property (dev_sda_oe |-> !standby)
        else $error("standby while driving the bus");
    cover property (start_seen);
    cover property (ninth && dev_sda_oe);
    cover property (stop_seen ##[1:12] write_busy);
endmodule

// ### testbench/tb_top.sv
// Bench: controller and memory end joined on one bus, driven by command calls.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 0;
    logic bus_clk = 0;
    logic rstn = 0;
    logic cmd_valid = 0;
    logic cmd_rd_ack = 0;
    logic tx_load = 0;
    logic scl_d = 1;
    logic cmd_ready, done, ack_seen, recovered, rx_valid, standby, write_busy;
    logic [7:0] cmd_wdata = 8'h00, tx_data = 8'h00, rdata, rx_data, rx_last, sh;
    seb_pkg::seb_cmd_t cmd = seb_pkg::SEB_CMD_START;
    int fails = 0, num_checks = 0, cyc = 0, n;
    seb_if bus ();
    always #20 sys_clk = !sys_clk;
    // Odd offset keeps the link clock out of step with the system clock.
    initial begin
        #1.3;
        forever #3 bus_clk = !bus_clk;
    end
    seb_host #(.QUARTER_CYC(4)) seb_host_i (.bus(bus.host), .sys_clk(sys_clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_wdata(cmd_wdata),
        .cmd_rd_ack(cmd_rd_ack), .done(done), .rdata(rdata), .ack_seen(ack_seen),
        .recovered(recovered));
    seb_device #(.WRITE_CYC(600)) seb_device_i (.bus(bus.dev), .sys_clk(sys_clk), .rstn(rstn),
        .bus_clk(bus_clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_load(tx_load),
        .tx_data(tx_data), .standby(standby), .write_busy(write_busy));
    seb_bus_properties #(.WRITE_CYC(600)) seb_bus_properties_i (.sys_clk(sys_clk),
        .rstn(rstn), .scl(bus.scl), .sda(bus.sda), .dev_sda_oe(bus.dev_sda_oe),
        .write_busy(write_busy), .standby(standby));
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        scl_d <= bus.scl;
        if (bus.scl && !scl_d) begin
            sh <= {sh[6:0], bus.sda};
        end
        if (rx_valid === 1'b1) begin
            rx_last <= rx_data;
        end
        if (cyc == 30000) begin
            fails++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The request is held until the edge that takes it, then the done pulse is awaited.
    task automatic run(input seb_pkg::seb_cmd_t c, input logic [7:0] d, input logic a);
        @(posedge sys_clk);
        while (cmd_ready !== 1'b1) begin
            @(posedge sys_clk);
        end
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_wdata <= d;
        cmd_rd_ack <= a;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        do @(posedge sys_clk); while (done !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] d, input logic exp_ack);
        run(seb_pkg::SEB_CMD_WRITE, d, 1'b0);
        chk({7'h00, ack_seen}, {7'h00, exp_ack});
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        n = 0;
        @(posedge sys_clk);
        while (cmd_ready !== 1'b1) begin
            @(posedge sys_clk);
            n++;
        end
        chk({7'h00, n >= seb_pkg::POWER_ON_CYC}, 8'h01);
        run(seb_pkg::SEB_CMD_RECOVER, 8'h00, 1'b0);
        chk({7'h00, recovered}, 8'h01);
        tx_data <= 8'h3a;
        tx_load <= 1'b1;
        @(posedge sys_clk);
        tx_load <= 1'b0;
        run(seb_pkg::SEB_CMD_START, 8'h00, 1'b0);
        wr(8'ha0, 1'b1);
        wr(8'h5c, 1'b1);
        chk(sh, 8'hb8);
        chk(rx_last, 8'h5c);
        run(seb_pkg::SEB_CMD_STOP, 8'h00, 1'b0);
        repeat (8) @(posedge sys_clk);
        chk({7'h00, write_busy}, 8'h01);
        run(seb_pkg::SEB_CMD_START, 8'h00, 1'b0);
        wr(8'ha0, 1'b0);
        run(seb_pkg::SEB_CMD_STOP, 8'h00, 1'b0);
        while (write_busy === 1'b1) begin
            @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        chk({7'h00, standby}, 8'h01);
        run(seb_pkg::SEB_CMD_START, 8'h00, 1'b0);
        wr(8'h90, 1'b0);
        run(seb_pkg::SEB_CMD_STOP, 8'h00, 1'b0);
        run(seb_pkg::SEB_CMD_START, 8'h00, 1'b0);
        wr(8'ha1, 1'b1);
        // The first read word is already latched, so a new load only reaches the second word.
        tx_data <= 8'hc5;
        tx_load <= 1'b1;
        @(posedge sys_clk);
        tx_load <= 1'b0;
        run(seb_pkg::SEB_CMD_READ, 8'h00, 1'b1);
        chk(rdata, 8'h3a);
        chk({7'h00, ack_seen}, 8'h01);
        run(seb_pkg::SEB_CMD_READ, 8'h00, 1'b0);
        chk(rdata, 8'hc5);
        run(seb_pkg::SEB_CMD_STOP, 8'h00, 1'b0);
        repeat (8) @(posedge sys_clk);
        chk({7'h00, standby}, 8'h01);
        finish_test();
    end
endmodule
